/* tsc_switch.sv */
/*
  tsc_switch: sequences the core clock source across resets, sleep and wake-up,
  running from the internal oscillator until the primary crystal has settled.
  Assumes power-up and start-up timer expiry arrive as one-cycle strobes from
  separate timer logic, and that all inputs are synchronous to core_clk_in.
*/
// The register addresses and the address-and-strobe port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// RULE1 - two-speed only when switchover bit set
// RULE2 - software enables it only for crystals
// RULE3 - reset and wake pick internal oscillator
// RULE4 - timer expiry switches to primary run
// RULE5 - software sets frequency before sleep
// RULE6 - other modes ignore switchover, keep source
// RULE7 - sleep and select honoured before expiry
// RULE8 - status bit 3 shows primary clocking
// RULE9 - timer strobes act on next edge
module tsc_switch (
  input wire logic core_clk_in, // core clock, 100 MHz
  input wire logic rst_in, // async reset, active high
  input wire tsc_pkg::tsc_req_t req_in, // register port request
  input wire logic por_in, // last reset was power-on
  input wire logic pwrt_expired_in, // power-up timer strobe
  input wire logic ost_expired_in, // start-up timer strobe
  input wire logic sleep_cmd_in, // sleep instruction strobe
  input wire logic wake_in, // wake-up event strobe
  output logic [tsc_pkg::DATA_W-1:0] rd_data_out, // read data, cycle after read
  output tsc_pkg::tsc_src_t clk_src_out, // selected core clock source
  output logic core_run_out, // core clock running
  output logic pri_osc_en_out, // primary oscillator powered
  output logic ost_start_out, // restart start-up timer, pulse
  output logic [tsc_pkg::IFS_W-1:0] int_freq_out, // internal oscillator frequency
  output logic startup_status_out // primary clocks the core
);
  import tsc_pkg::*;

  tsc_state_t state;
  tsc_state_t next_state;
  logic [SCS_W-1:0] system_clock_select;
  logic [0:0] switchover_config_bit;
  logic ctrl_wr;
  logic cfg_wr;
  logic scs_wr_alt;
  logic pri_ready;
  logic start_ok;

  // address decode for writes
  always_comb
  begin
    ctrl_wr = 1'b0;
    cfg_wr = 1'b0;
    if (req_in.wr && req_in.addr == OSC_CONTROL_REG_OFS)
    begin
      ctrl_wr = 1'b1;
    end
    else if (req_in.wr && req_in.addr == STARTUP_CFG_REG_OFS)
    begin
      cfg_wr = 1'b1;
    end
  end

  // select fields, reset by every reset; the frequency flop drives the oscillator
  tsc_field #(.W(IFS_W), .RST(IFS_RST)) u_ifs (
    .core_clk_in(core_clk_in),
    .rst_in(rst_in),
    .wr_en_in(ctrl_wr),
    .wdata_in(req_in.wdata[IFS_LSB +: IFS_W]),
    .q_out(int_freq_out)
  );
  tsc_field #(.W(SCS_W), .RST(SCS_RST)) u_scs (
    .core_clk_in(core_clk_in),
    .rst_in(rst_in),
    .wr_en_in(ctrl_wr),
    .wdata_in(req_in.wdata[SCS_LSB +: SCS_W]),
    .q_out(system_clock_select)
  );
  tsc_field #(.W(1), .RST(SWITCHOVER_RST)) u_cfg (
    .core_clk_in(core_clk_in),
    .rst_in(rst_in),
    .wr_en_in(cfg_wr),
    .wdata_in(req_in.wdata[SWITCHOVER_BIT +: 1]),
    .q_out(switchover_config_bit)
  );

  assign scs_wr_alt = ctrl_wr && req_in.wdata[SCS_LSB +: SCS_W] != SCS_PRIMARY;
  // two-speed path only when primary selected and feature enabled
  assign start_ok = switchover_config_bit[0] && system_clock_select == SCS_PRIMARY; // see RULE1

  // primary oscillator settled; set wins over the clear by sleep
  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      pri_ready <= 1'b0;
    end
    else if (ost_expired_in)
    begin
      pri_ready <= 1'b1;
    end
    else if (next_state == TSC_SLEEP)
    begin
      pri_ready <= 1'b0;
    end
  end

  // sequencer next state
  always_comb
  begin
    next_state = state;
    case (state)
      TSC_BOOT:
      begin
        next_state = por_in ? TSC_PWRT_WAIT : start_ok ? TSC_INT_RUN : TSC_OST_HOLD; // see RULE3
      end
      TSC_PWRT_WAIT:
      begin
        if (pwrt_expired_in)
        begin
          next_state = start_ok ? TSC_INT_RUN : TSC_OST_HOLD; // see RULE3 see RULE9
        end
      end
      TSC_INT_RUN:
      begin
        if (sleep_cmd_in)
        begin
          next_state = TSC_SLEEP; // see RULE7
        end
        else if (scs_wr_alt)
        begin
          next_state = TSC_ALT_RUN; // see RULE7
        end
        else if (ost_expired_in)
        begin
          next_state = TSC_PRIMARY_RUN; // see RULE4 see RULE9
        end
      end
      TSC_OST_HOLD:
      begin
        if (ost_expired_in)
        begin
          next_state = TSC_PRIMARY_RUN;
        end
      end
      TSC_PRIMARY_RUN:
      begin
        if (sleep_cmd_in)
        begin
          next_state = TSC_SLEEP;
        end
        else if (scs_wr_alt)
        begin
          next_state = TSC_ALT_RUN;
        end
      end
      TSC_ALT_RUN:
      begin
        if (sleep_cmd_in)
        begin
          next_state = TSC_SLEEP;
        end
        else if (system_clock_select == SCS_PRIMARY && (pri_ready || ost_expired_in))
        begin
          next_state = TSC_PRIMARY_RUN; // see RULE6
        end
      end
      TSC_SLEEP:
      begin
        if (wake_in)
        begin
          next_state = start_ok ? TSC_INT_RUN : // see RULE3 see RULE1
                       system_clock_select == SCS_PRIMARY ? TSC_OST_HOLD : TSC_ALT_RUN; // start_ok clear, see RULE6
        end
      end
      default:
      begin
        next_state = TSC_BOOT;
      end
    endcase
  end

  // state register
  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      state <= TSC_BOOT;
    end
    else
    begin
      state <= next_state;
    end
  end

  // registered clock controls, taken from the next state; ost_start_out also compares it with the current state
  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      clk_src_out <= TSC_SRC_INTERNAL;
      core_run_out <= 1'b0;
      pri_osc_en_out <= 1'b0;
      ost_start_out <= 1'b0;
      startup_status_out <= 1'b0;
    end
    else
    begin
      core_run_out <= next_state != TSC_BOOT && next_state != TSC_PWRT_WAIT &&
                      next_state != TSC_OST_HOLD && next_state != TSC_SLEEP;
      pri_osc_en_out <= next_state != TSC_SLEEP && next_state != TSC_BOOT;
      ost_start_out <= (next_state == TSC_INT_RUN || next_state == TSC_OST_HOLD ||
                        (next_state == TSC_ALT_RUN && state == TSC_SLEEP)) && next_state != state;
      startup_status_out <= next_state == TSC_PRIMARY_RUN; // see RULE8
      if (next_state == TSC_PRIMARY_RUN || next_state == TSC_OST_HOLD)
      begin
        clk_src_out <= TSC_SRC_PRIMARY; // see RULE4
      end
      else if (next_state == TSC_ALT_RUN && system_clock_select == SCS_SECONDARY)
      begin
        clk_src_out <= TSC_SRC_SECONDARY; // see RULE6
      end
      else if (next_state == TSC_ALT_RUN || next_state == TSC_INT_RUN)
      begin
        clk_src_out <= TSC_SRC_INTERNAL; // see RULE3
      end
    end
  end

  // read port, data valid only in the cycle after the strobe
  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      rd_data_out <= RD_ZERO;
    end
    else if (req_in.rd && req_in.addr == OSC_CONTROL_REG_OFS)
    begin
      rd_data_out <= RD_ZERO;
      rd_data_out[IFS_LSB +: IFS_W] <= int_freq_out;
      rd_data_out[STARTUP_STATUS_BIT] <= state == TSC_PRIMARY_RUN; // see RULE8
      rd_data_out[SCS_LSB +: SCS_W] <= system_clock_select;
    end
    else if (req_in.rd && req_in.addr == STARTUP_CFG_REG_OFS)
    begin
      rd_data_out <= RD_ZERO;
      rd_data_out[SWITCHOVER_BIT] <= switchover_config_bit[0];
    end
    else
    begin
      rd_data_out <= RD_ZERO;
    end
  end

  // checks
  sequence s_int_running;
    state == TSC_INT_RUN && !sleep_cmd_in && !scs_wr_alt;
  endsequence

  sequence s_ost_done;
    ost_expired_in ##1 1'b1;
  endsequence

  a_ost_to_primary: assert property (@(posedge core_clk_in) disable iff (rst_in) // see RULE4
    s_int_running ##0 s_ost_done |-> state == TSC_PRIMARY_RUN && clk_src_out == TSC_SRC_PRIMARY)
    else $error("start-up timer expiry did not switch to primary");
  a_wake_internal: assert property (@(posedge core_clk_in) disable iff (rst_in) // see RULE3
    state == TSC_SLEEP && wake_in && start_ok |=> clk_src_out == TSC_SRC_INTERNAL && core_run_out)
    else $error("wake-up did not run from internal oscillator");
  a_pwrt_gate: assert property (@(posedge core_clk_in) disable iff (rst_in) // see RULE3
    state == TSC_PWRT_WAIT && !pwrt_expired_in |=> !core_run_out)
    else $error("core ran before power-up timer expiry");
  a_no_twospeed_off: assert property (@(posedge core_clk_in) disable iff (rst_in) // see RULE1
    !start_ok |-> ##1 state != TSC_INT_RUN || $past(state) == TSC_INT_RUN)
    else $error("two-speed entered while disabled");
  a_alt_keeps_source: assert property (@(posedge core_clk_in) disable iff (rst_in) // see RULE6
    state == TSC_ALT_RUN && !pri_ready && !ost_expired_in && !sleep_cmd_in |=> state == TSC_ALT_RUN)
    else $error("left selected source before primary ready");
  a_sleep_early: assert property (@(posedge core_clk_in) disable iff (rst_in) // see RULE7
    state == TSC_INT_RUN && sleep_cmd_in |=> state == TSC_SLEEP && !core_run_out)
    else $error("sleep during two-speed start-up not honoured");
  a_status_read: assert property (@(posedge core_clk_in) disable iff (rst_in) // see RULE8
    req_in.rd && req_in.addr == OSC_CONTROL_REG_OFS |=>
      rd_data_out[STARTUP_STATUS_BIT] == ($past(state) == TSC_PRIMARY_RUN))
    else $error("status bit does not match clock source");
  a_status_out: assert property (@(posedge core_clk_in) disable iff (rst_in) // see RULE8
    startup_status_out == (clk_src_out == TSC_SRC_PRIMARY && core_run_out))
    else $error("status output disagrees with source");
  a_pwrt_strobe: assert property (@(posedge core_clk_in) disable iff (rst_in) // see RULE9
    state == TSC_PWRT_WAIT && pwrt_expired_in && start_ok |=> state == TSC_INT_RUN && ost_start_out)
    else $error("power-up strobe not acted on next edge");

endmodule

`default_nettype wire

/* tsc_pkg.sv */
/*
  tsc_pkg: constants, types and register layout for the two-speed start-up clock switch.
  Assumes a single 100 MHz core clock and a plain strobe-based register port.
*/
`default_nettype none

package tsc_pkg;

  // register port geometry
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;

  // register offsets
  localparam logic [ADDR_W-1:0] OSC_CONTROL_REG_OFS = 4'h0;
  localparam logic [ADDR_W-1:0] STARTUP_CFG_REG_OFS = 4'h1;

  // osc_control_reg field positions
  localparam int IFS_LSB = 4;
  localparam int IFS_W = 3;
  localparam int STARTUP_STATUS_BIT = 3;
  localparam int SCS_LSB = 0;
  localparam int SCS_W = 2;

  // startup_cfg_reg field positions
  localparam int SWITCHOVER_BIT = 0;

  // values after reset
  localparam logic [IFS_W-1:0] IFS_RST = 3'h4;
  localparam logic [SCS_W-1:0] SCS_RST = 2'h0;
  localparam logic [0:0] SWITCHOVER_RST = 1'h1;
  localparam logic [DATA_W-1:0] RD_ZERO = 8'h00;

  // system clock select encodings
  localparam logic [SCS_W-1:0] SCS_PRIMARY = 2'h0;
  localparam logic [SCS_W-1:0] SCS_SECONDARY = 2'h1;

  // core clock source on the glitch-free mux
  typedef enum logic [1:0] {
    TSC_SRC_PRIMARY = 2'h0,
    TSC_SRC_SECONDARY = 2'h1,
    TSC_SRC_INTERNAL = 2'h2
  } tsc_src_t;

  // sequencer states, gray along boot, pwrt, internal, primary, sleep
  typedef enum logic [2:0] {
    TSC_BOOT = 3'h0,
    TSC_PWRT_WAIT = 3'h1,
    TSC_INT_RUN = 3'h3,
    TSC_PRIMARY_RUN = 3'h2,
    TSC_SLEEP = 3'h6,
    TSC_ALT_RUN = 3'h7,
    TSC_OST_HOLD = 3'h4
  } tsc_state_t;

  // register port request
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } tsc_req_t;

endpackage

`default_nettype wire

/* tsc_field.sv */
/*
  tsc_field: one software-writable register field with a reset value.
  Assumes the caller decodes address and write strobe into one enable.
*/
`timescale 1ns/1ps
`default_nettype none

module tsc_field #(
  parameter int W = 1,
  parameter logic [W-1:0] RST = '0
) (
  input wire logic core_clk_in, // core clock
  input wire logic rst_in, // async reset, active high
  input wire logic wr_en_in, // write this field
  input wire logic [W-1:0] wdata_in, // new value
  output logic [W-1:0] q_out // stored value
);

  // field storage
  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      q_out <= RST;
    end
    else if (wr_en_in)
    begin
      q_out <= wdata_in;
    end
  end

endmodule

`default_nettype wire

/* tsc_pri_osc.sv */
/*
  tsc_pri_osc: behavioural primary crystal oscillator with its start-up timer.
  Assumes the restart pulse and the power enable come from the switch on the core clock.
*/
`timescale 1ns/1ps
`default_nettype none

module tsc_pri_osc #(
  parameter int OST_CYC = 20
) (
  input wire logic core_clk_in, // core clock
  input wire logic rst_in, // async reset, active high
  input wire logic pri_osc_en_in, // crystal powered
  input wire logic ost_start_in, // restart timer, pulse
  output logic ost_expired_out // timer expiry, pulse
);
  int cnt;

  // crystal mode, so every restart runs the full settle count
  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      cnt <= 0;
      ost_expired_out <= 1'b0;
    end
    else
    begin
      ost_expired_out <= (cnt == 1) && pri_osc_en_in && !ost_start_in;
      if (ost_start_in)
        cnt <= OST_CYC;
      else if (!pri_osc_en_in)
        cnt <= 0; // powered down, crystal stops
      else if (cnt != 0)
        cnt <= cnt - 1;
    end
  end
endmodule

`default_nettype wire

/* tsc_switch_tb.sv */
/*
  tsc_switch_tb: self-checking bench for the two-speed start-up switch.
  Assumes the crystal model drives the start-up timer strobe back into the switch.
*/
`timescale 1ns/1ps
`default_nettype none

module tsc_switch_tb;
  import tsc_pkg::*;
  localparam int OST_CYC = 20;
  logic clk = 1'b0;
  logic rst = 1'b1;
  tsc_req_t req = '0;
  logic por = 1'b0;
  logic pwrt = 1'b0;
  logic slp = 1'b0;
  logic wake = 1'b0;
  logic osc_startup_timer;
  logic [DATA_W-1:0] rdata;
  tsc_src_t src;
  logic run;
  logic pen;
  logic ost_go;
  logic sts;
  logic [IFS_W-1:0] ifs;
  int n_errors = 0;
  int n_tests = 0;
  int cyc = 0;

  // clock
  always #5 clk = ~clk;

  tsc_switch DUT (.core_clk_in(clk), .rst_in(rst), .req_in(req), .por_in(por), .pwrt_expired_in(pwrt),
    .ost_expired_in(osc_startup_timer), .sleep_cmd_in(slp), .wake_in(wake), .rd_data_out(rdata), .clk_src_out(src),
    .core_run_out(run), .pri_osc_en_out(pen), .ost_start_out(ost_go), .int_freq_out(ifs),
    .startup_status_out(sts));

  tsc_pri_osc #(.OST_CYC(OST_CYC)) u_osc (.core_clk_in(clk), .rst_in(rst), .pri_osc_en_in(pen),
    .ost_start_in(ost_go), .ost_expired_out(osc_startup_timer));

  task automatic give_verdict();
    $display("tests %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp)
    begin
      n_errors++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // one-cycle register write
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    req.wr <= 1'b0;
  endtask

  // one-cycle read, data checked in the following cycle
  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    @(posedge clk);
    req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    req.rd <= 1'b0;
    #1;
    chk("rd_data", exp, rdata);
  endtask

  // 0 sleep, 1 wake, 2 power-up timer; returns once the strobe is taken
  task automatic pulse(input int k);
    @(posedge clk);
    slp <= (k == 0);
    wake <= (k == 1);
    pwrt <= (k == 2);
    @(posedge clk);
    slp <= 1'b0;
    wake <= 1'b0;
    pwrt <= 1'b0;
    #1;
  endtask

  task automatic wait_ost(input tsc_src_t exp_src);
    int i;
    for (i = 0; i < 100 && osc_startup_timer !== 1'b1; i++)
    begin
      @(posedge clk);
      #1;
    end
    @(posedge clk);
    #1;
    chk("src_after_ost", 8'(exp_src), 8'(src));
  endtask

  task automatic do_reset(input logic p);
    rst <= 1'b1;
    por <= p;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
  endtask

  task automatic t_boot();
    do_reset(1'b0);
    @(posedge clk);
    #1;
    chk("src", 8'(TSC_SRC_INTERNAL), 8'(src));
    chk("run", 8'h01, {7'h00, run});
    chk("ost_start", 8'h01, {7'h00, ost_go});
    rd(4'h0, 8'h40);
    rd(4'h1, 8'h01);
    rd(4'hf, 8'h00);
    wait_ost(TSC_SRC_PRIMARY);
    chk("status", 8'h01, {7'h00, sts});
    rd(4'h0, 8'h48);
    $display("boot test done");
  endtask

  task automatic t_sleep_wake();
    wr(4'h0, 8'h60);
    rd(4'h0, 8'h68);
    chk("int_freq", 8'h06, {5'h00, ifs});
    pulse(0);
    chk("run_sleep", 8'h00, {7'h00, run});
    chk("pri_en_sleep", 8'h00, {7'h00, pen});
    pulse(1);
    chk("src_wake", 8'(TSC_SRC_INTERNAL), 8'(src));
    chk("status_wake", 8'h00, {7'h00, sts});
    pulse(0);
    chk("run_resleep", 8'h00, {7'h00, run});
    pulse(1);
    wr(4'h0, 8'h61);
    @(posedge clk);
    #1;
    chk("src_select", 8'(TSC_SRC_SECONDARY), 8'(src));
    wait_ost(TSC_SRC_SECONDARY);
    wr(4'h0, 8'h60);
    repeat (2) @(posedge clk);
    #1;
    chk("src_back", 8'(TSC_SRC_PRIMARY), 8'(src));
    chk("status_back", 8'h01, {7'h00, sts});
    $display("sleep wake test done");
  endtask

  task automatic t_disabled();
    wr(4'h1, 8'h00);
    rd(4'h1, 8'h00);
    pulse(0);
    pulse(1);
    chk("src_not_int", 8'h01, {7'h00, src !== TSC_SRC_INTERNAL});
    chk("run_hold", 8'h00, {7'h00, run});
    chk("ost_start_hold", 8'h01, {7'h00, ost_go});
    wait_ost(TSC_SRC_PRIMARY);
    chk("status_dis", 8'h01, {7'h00, sts});
    wr(4'h1, 8'h01);
    $display("disabled test done");
  endtask

  task automatic t_por();
    do_reset(1'b1);
    repeat (3) @(posedge clk);
    #1;
    chk("run_pwrt", 8'h00, {7'h00, run});
    pulse(2);
    chk("src_pwrt", 8'(TSC_SRC_INTERNAL), 8'(src));
    chk("run_after_pwrt", 8'h01, {7'h00, run});
    wait_ost(TSC_SRC_PRIMARY);
    $display("power-on test done");
  endtask

  // cut a hang short
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      n_errors++;
      give_verdict();
    end
  end

  initial
  begin
    t_boot();
    t_sleep_wake();
    t_disabled();
    t_por();
    give_verdict();
  end
endmodule

`default_nettype wire
